// ---- rtl/routed_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module routed_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Filling and draining sides
    stream_if.sink fill,
    stream_if.source drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic [WIDTH-1:0] head, next_head;
    logic push, pop;

    assign fill.ready = (count != (AW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.data = head;
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
        if (next_count == '0) begin
            next_head = '0;
        end else if (push && (count == '0 || (pop && count == (AW+1)'(1)))) begin
            next_head = fill.data;
        end else begin
            next_head = mem[next_rd_ptr];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            head <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            head <= next_head;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end
endmodule

// ---- rtl/serial_interface_mode_control.sv ----
// Serial line interface mode register, framing, strobes, diagnostics and routing
// Behaviour
// - Force-zero bit set drives line transmit data low; clear leaves normal transmit.
// - Sync style clear: pulse precedes 8-bit channel; set: sync envelopes the data.
// - Diagnostic field picks normal, automatic echo, internal loopback or loopback control.
// - Second channel asserts strobe two when its bit is 0, strobe one when 1.
// - First channel asserts strobe one when its bit is 0, strobe two when 1.
// - Second channel route: none, controller 1, 2 or 3 when mux select clear.
// - First channel route uses same encoding and the same mux select conditions.
// - Controller state holds indefinitely while an external clock stands high or low.
// - Internal baud generator is never gated; gating works only with external clock.
// - External clock phase shorter than minimum flags underrun or overrun at once.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module serial_interface_mode_control
    import sim_ctl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int BAUD_DIVIDE = BAUD_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [REG_DW-1:0] reg_rdata,
    // Line pins
    input wire logic line_clk_pin,
    input wire logic line_sync_pin,
    input wire logic line_rx_pin,
    output logic line_tx_data,
    output logic data_strobe_one,
    output logic data_strobe_two,
    // Controller transmit bit
    input wire logic ctrl_tx_bit,
    // Routed channel stream: {controller code, byte}
    output logic out_valid,
    input wire logic out_ready,
    output logic [ROUTED_W-1:0] out_data
);
    localparam int PW = $clog2(MIN_PHASE_CYCLES + 1);
    localparam int DW = $clog2(BAUD_DIVIDE);

    // Route decode: code, or none when unsupported or multiplexed away
    function automatic logic route_ok(input logic [1:0] code, input logic mux2,
                                      input logic mux3);
        case (code)
            ROUTE_CTRL1: route_ok = 1'b1;
            ROUTE_CTRL2: route_ok = !mux2;
            ROUTE_CTRL3: route_ok = !mux3;
            default: route_ok = 1'b0;
        endcase
    endfunction

    // Registers
    logic [REG_DW-1:0] mode, next_mode;
    logic [REG_DW-1:0] config_reg, next_config_reg;
    logic [ST_WIDTH-1:0] status, next_status;
    logic [REG_DW-1:0] next_reg_rdata;

    // Pin synchronisers
    logic clk_meta, clk_sync, clk_prev;
    logic sync_meta, sync_sync;
    logic rx_meta, rx_sync;

    // Baud divider
    logic [DW-1:0] baud_cnt, next_baud_cnt;
    logic baud_tick;

    // Phase monitor
    logic [PW-1:0] phase_cnt, next_phase_cnt;
    logic phase_short_hi, phase_short_lo;

    // Framing
    frame_state_e state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [CHAN_BITS-1:0] shift, next_shift;
    logic next_line_tx_data, next_strobe_one, next_strobe_two;
    logic bit_edge, take_bit, rx_bit, byte_done, done_second;
    logic [1:0] route_code;
    logic [CHAN_BITS-1:0] byte_val;
    diag_e diag;

    stream_if #(.WIDTH(ROUTED_W)) fill_bus ();
    stream_if #(.WIDTH(ROUTED_W)) drain_bus ();

    routed_fifo #(.WIDTH(ROUTED_W), .DEPTH(DEPTH)) fifo_inst (
        .ref_clk(ref_clk),
        .reset(reset),
        .fill(fill_bus),
        .drain(drain_bus)
    );

    assign out_valid = drain_bus.valid;
    assign out_data = drain_bus.data;
    assign drain_bus.ready = out_ready;

    // Pins pass two flops before use
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
            sync_meta <= 1'b0;
            sync_sync <= 1'b0;
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            clk_meta <= line_clk_pin;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
            sync_meta <= line_sync_pin;
            sync_sync <= sync_meta;
            rx_meta <= line_rx_pin;
            rx_sync <= rx_meta;
        end
    end

    assign diag = diag_e'({mode[DIAG_HI_BIT], mode[DIAG_LO_BIT]});

    // Divider and phase monitor
    always_comb begin
        next_baud_cnt = (baud_cnt == DW'(BAUD_DIVIDE - 1)) ? '0 : DW'(baud_cnt + 1'b1);
        baud_tick = (baud_cnt == DW'(BAUD_DIVIDE - 1));
        if (clk_sync != clk_prev) begin
            next_phase_cnt = PW'(1);
        end else if (phase_cnt != PW'(MIN_PHASE_CYCLES)) begin
            next_phase_cnt = PW'(phase_cnt + 1'b1);
        end else begin
            next_phase_cnt = phase_cnt;
        end
        phase_short_hi = config_reg[CFG_EXT_CLK_BIT] && clk_prev && !clk_sync
                         && (phase_cnt < PW'(MIN_PHASE_CYCLES));
        phase_short_lo = config_reg[CFG_EXT_CLK_BIT] && !clk_prev && clk_sync
                         && (phase_cnt < PW'(MIN_PHASE_CYCLES));
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            baud_cnt <= '0;
            phase_cnt <= '0;
        end else begin
            baud_cnt <= next_baud_cnt;
            phase_cnt <= next_phase_cnt;
        end
    end

    // Framing, strobes, transmit and routing
    always_comb begin
        // External clock: no edge means no step, state holds as long as needed
        bit_edge = config_reg[CFG_EXT_CLK_BIT] ? (clk_sync && !clk_prev)
                                                : baud_tick;
        rx_bit = (diag == DIAG_INT_LOOP || diag == DIAG_LOOP_CTRL) ? ctrl_tx_bit
                                                                   : rx_sync;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        take_bit = 1'b0;
        byte_done = 1'b0;
        done_second = 1'b0;
        if (phase_short_hi || phase_short_lo) begin
            next_state = FR_IDLE;
            next_bit_cnt = '0;
        end else if (bit_edge) begin
            unique case (state)
                FR_IDLE: begin
                    if (sync_sync) begin
                        next_state = FR_FIRST;
                        next_bit_cnt = '0;
                        take_bit = mode[SYNC_STYLE_BIT];
                    end
                end
                FR_FIRST, FR_SECOND: begin
                    if (mode[SYNC_STYLE_BIT] && !sync_sync) begin
                        next_state = FR_IDLE;
                        next_bit_cnt = '0;
                    end else begin
                        take_bit = 1'b1;
                    end
                end
            endcase
            if (take_bit) begin
                next_shift = {shift[CHAN_BITS-2:0], rx_bit};
                next_bit_cnt = 3'(bit_cnt + 1'b1);
                if (bit_cnt == LAST_BIT) begin
                    byte_done = 1'b1;
                    done_second = (state == FR_SECOND);
                    next_state = (state == FR_SECOND) ? FR_IDLE : FR_SECOND;
                end
            end
        end
        byte_val = {shift[CHAN_BITS-2:0], rx_bit};
        route_code = done_second
            ? {mode[SECOND_ROUTE_HI_BIT], mode[SECOND_ROUTE_LO_BIT]}
            : {mode[FIRST_ROUTE_HI_BIT], mode[FIRST_ROUTE_LO_BIT]};
        fill_bus.valid = byte_done
            && route_ok(route_code, mode[MUX_CTRL2_BIT], mode[MUX_CTRL3_BIT]);
        fill_bus.data = {route_code, byte_val};

        // Strobes follow the channel being shifted
        next_strobe_one = 1'b0;
        next_strobe_two = 1'b0;
        if (next_state == FR_FIRST) begin
            next_strobe_one = !mode[STROBE_FIRST_BIT];
            next_strobe_two = mode[STROBE_FIRST_BIT];
        end else if (next_state == FR_SECOND) begin
            next_strobe_two = !mode[STROBE_SECOND_BIT];
            next_strobe_one = mode[STROBE_SECOND_BIT];
        end

        unique case (diag)
            DIAG_NORMAL: next_line_tx_data = ctrl_tx_bit;
            DIAG_ECHO: next_line_tx_data = rx_sync;
            DIAG_INT_LOOP: next_line_tx_data = 1'b1;
            DIAG_LOOP_CTRL: next_line_tx_data = ctrl_tx_bit;
        endcase
        if (mode[FORCE_ZERO_BIT]) begin
            next_line_tx_data = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= FR_IDLE;
            bit_cnt <= '0;
            shift <= '0;
            line_tx_data <= 1'b1;
            data_strobe_one <= 1'b0;
            data_strobe_two <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            line_tx_data <= next_line_tx_data;
            data_strobe_one <= next_strobe_one;
            data_strobe_two <= next_strobe_two;
        end
    end

    // Register file; status flags clear on writing one, a new event wins
    always_comb begin
        next_mode = mode;
        next_config_reg = config_reg;
        next_status = status;
        if (reg_write && reg_addr == ADDR_MODE) begin
            next_mode = reg_wdata;
        end
        if (reg_write && reg_addr == ADDR_CONFIG) begin
            next_config_reg = reg_wdata & 16'h0001;
        end
        if (reg_write && reg_addr == ADDR_STATUS) begin
            next_status = status & ~reg_wdata[ST_WIDTH-1:0];
        end
        if (phase_short_hi) begin
            next_status[ST_UNDERRUN_BIT] = 1'b1;
        end
        if (phase_short_lo) begin
            next_status[ST_OVERRUN_BIT] = 1'b1;
        end
        if (byte_done && !fill_bus.valid) begin
            next_status[ST_DROP_BIT] = 1'b1;
        end
        if (fill_bus.valid && !fill_bus.ready) begin
            next_status[ST_FIFO_OVF_BIT] = 1'b1;
        end
        next_reg_rdata = READ_ZERO;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_MODE: next_reg_rdata = mode;
                ADDR_CONFIG: next_reg_rdata = config_reg;
                ADDR_STATUS: begin
                    next_reg_rdata[ST_WIDTH-1:0] = status;
                    next_reg_rdata[ST_STATE_LO_BIT +: 2] = state;
                    next_reg_rdata[ST_FIFO_VALID_BIT] = drain_bus.valid;
                end
                ADDR_FIFO: next_reg_rdata[ROUTED_W-1:0] = drain_bus.data;
                default: next_reg_rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode <= MODE_RESET;
            config_reg <= CONFIG_RESET;
            status <= '0;
            reg_rdata <= READ_ZERO;
        end else begin
            mode <= next_mode;
            config_reg <= next_config_reg;
            status <= next_status;
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule

// ---- rtl/sim_ctl_pkg.sv ----
// Constants and types shared by the serial interface mode control design
package sim_ctl_pkg;

    // Register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_FIFO = 4'h3;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // Mode register fields
    localparam int FORCE_ZERO_BIT = 15;
    localparam int SYNC_STYLE_BIT = 14;
    localparam int DIAG_HI_BIT = 13;
    localparam int DIAG_LO_BIT = 12;
    localparam int STROBE_SECOND_BIT = 11;
    localparam int STROBE_FIRST_BIT = 10;
    localparam int SECOND_ROUTE_HI_BIT = 9;
    localparam int SECOND_ROUTE_LO_BIT = 8;
    localparam int FIRST_ROUTE_HI_BIT = 7;
    localparam int FIRST_ROUTE_LO_BIT = 6;
    localparam int MUX_CTRL3_BIT = 3;
    localparam int MUX_CTRL2_BIT = 2;

    // Config register fields
    localparam int CFG_EXT_CLK_BIT = 0;

    // Status register fields
    localparam int ST_UNDERRUN_BIT = 0;
    localparam int ST_OVERRUN_BIT = 1;
    localparam int ST_DROP_BIT = 2;
    localparam int ST_FIFO_OVF_BIT = 3;
    localparam int ST_STATE_LO_BIT = 4;
    localparam int ST_FIFO_VALID_BIT = 6;
    localparam int ST_WIDTH = 4;

    typedef enum logic [1:0] {
        DIAG_NORMAL = 2'b00,
        DIAG_ECHO = 2'b01,
        DIAG_INT_LOOP = 2'b10,
        DIAG_LOOP_CTRL = 2'b11
    } diag_e;

    localparam logic [1:0] ROUTE_NONE = 2'b00;
    localparam logic [1:0] ROUTE_CTRL1 = 2'b01;
    localparam logic [1:0] ROUTE_CTRL2 = 2'b10;
    localparam logic [1:0] ROUTE_CTRL3 = 2'b11;

    // Channel framing
    localparam int CHAN_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int ROUTED_W = 2 + CHAN_BITS;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_PHASE_NS = 40;
    localparam int MIN_PHASE_CYCLES = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 32;
    localparam int BAUD_DIV = 16;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_FIRST,
        FR_SECOND
    } frame_state_e;

endpackage

// ---- rtl/stream_if.sv ----
// Valid/ready stream carrying routed channel bytes between modules
`timescale 1ns/1ns
interface stream_if #(
    parameter int WIDTH = 10
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ---- testbench/line_xcvr_model.sv ----
// Line transceiver model: external serial clock, frame sync and receive data
`timescale 1ns/1ns
module line_xcvr_model (
    // Clock
    input wire logic ref_clk,
    // Line pins
    output logic line_clk_pin,
    output logic line_sync_pin,
    output logic line_rx_pin
);
    int bit_no = 0;
    initial begin
        line_clk_pin = 1'b0;
        line_sync_pin = 1'b0;
        line_rx_pin = 1'b1;
    end
    // One bit: low phase of 7 cycles, high phase of hi cycles, clock then stands low
    task automatic pulse(input int hi, input logic d, input logic s);
        @(posedge ref_clk);
        line_rx_pin <= d;
        line_sync_pin <= s;
        repeat (6) @(posedge ref_clk);
        line_clk_pin <= 1'b1;
        bit_no <= bit_no + 1;
        repeat (hi) @(posedge ref_clk);
        line_clk_pin <= 1'b0;
    endtask
    // Sync bit then two 8-bit channels, or sync enveloping both; most significant first
    task automatic send_frame(input logic [7:0] b1, input logic [7:0] b2, input logic env);
        logic [15:0] w;
        w = {b1, b2};
        bit_no <= 0;
        if (!env) begin
            pulse(6, ~w[15], 1'b1);
        end
        for (int i = 15; i >= 0; i--) begin
            pulse(6, w[i], env);
        end
        @(posedge ref_clk);
        line_rx_pin <= ~w[0];
        line_sync_pin <= 1'b0;
    endtask
endmodule

// ---- testbench/sim_mode_monitor.sv ----
// Checker on the ports of the serial interface mode control block
`timescale 1ns/1ns
module sim_mode_monitor
    import sim_ctl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int BAUD_DIVIDE = BAUD_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [REG_DW-1:0] reg_rdata,
    // Line pins
    input wire logic line_clk_pin,
    input wire logic line_sync_pin,
    input wire logic line_rx_pin,
    input wire logic line_tx_data,
    input wire logic data_strobe_one,
    input wire logic data_strobe_two,
    // Controller and stream
    input wire logic ctrl_tx_bit,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [ROUTED_W-1:0] out_data
);
    logic [15:0] mode;
    logic [15:0] next_mode;
    // Shadow of the mode register, taken from the writes
    always_comb begin
        next_mode = mode;
        if (reset) begin
            next_mode = MODE_RESET;
        end else if (reg_write && reg_addr == ADDR_MODE) begin
            next_mode = reg_wdata;
        end
    end
    always_ff @(posedge ref_clk) begin
        mode <= next_mode;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence plain_map;
        !$past(reset) && $past(mode[11:10]) == 2'b00;
    endsequence
    sequence swap_map;
        !$past(reset) && $past(mode[11:10]) == 2'b11;
    endsequence
    chk_force_zero_low: assert property (!$past(reset) && $past(mode[15]) |-> !line_tx_data)
        else $error("transmit line not low under force zero");
    chk_normal_tx_path: assert property (!$past(reset) && $past(mode[15:12]) == 4'h0
        |-> line_tx_data == $past(ctrl_tx_bit)) else $error("normal transmit path wrong");
    chk_loop_ctl_path: assert property (!$past(reset) && $past(mode[15:12]) == 4'h3
        |-> line_tx_data == $past(ctrl_tx_bit)) else $error("loop control transmit wrong");
    chk_int_loop_high: assert property (!$past(reset) && $past(mode[15:12]) == 4'h2
        |-> line_tx_data) else $error("internal loopback line not high");
    chk_mode_read_back: assert property (reg_read && reg_addr == ADDR_MODE
        |=> reg_rdata == $past(mode)) else $error("mode read back wrong");
    chk_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == READ_ZERO)
        else $error("read data not zero outside read");
    chk_unmapped_zero: assert property (reg_read && reg_addr > ADDR_FIFO |=> reg_rdata == READ_ZERO)
        else $error("unmapped read not zero");
    chk_strobe_one_hot: assert property (!(data_strobe_one && data_strobe_two))
        else $error("both strobes high");
    chk_second_after_first: assert property (plain_map ##0 $rose(data_strobe_two)
        |-> $past(data_strobe_one)) else $error("second channel strobe out of order");
    chk_swapped_order: assert property (swap_map ##0 $rose(data_strobe_one)
        |-> $past(data_strobe_two)) else $error("swapped strobe out of order");
    chk_head_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stream head changed while stalled");
endmodule
bind serial_interface_mode_control sim_mode_monitor #(.DEPTH(DEPTH), .BAUD_DIVIDE(BAUD_DIVIDE))
    u_mon (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .line_clk_pin(line_clk_pin), .line_sync_pin(line_sync_pin), .line_rx_pin(line_rx_pin),
    .line_tx_data(line_tx_data), .data_strobe_one(data_strobe_one),
    .data_strobe_two(data_strobe_two), .ctrl_tx_bit(ctrl_tx_bit), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial interface mode control block
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
    import sim_ctl_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [REG_AW-1:0] reg_addr = 4'h0;
    logic [REG_DW-1:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic ctrl_tx_bit = 1'b0;
    logic out_ready = 1'b0;
    logic [REG_DW-1:0] reg_rdata;
    logic line_clk_pin, line_sync_pin, line_rx_pin;
    logic line_tx_data, data_strobe_one, data_strobe_two, out_valid;
    logic [ROUTED_W-1:0] out_data;
    logic [1:0] strobes;
    logic [15:0] rd;
    logic [ROUTED_W-1:0] exp_q[$];
    logic [15:0] modes [5] = '{16'h0240, 16'h0dc0, 16'h0484, 16'h0b44, 16'h4240};
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    assign strobes = {data_strobe_two, data_strobe_one};
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    serial_interface_mode_control #(.DEPTH(FIFO_DEPTH), .BAUD_DIVIDE(4)) DUT (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .line_clk_pin(line_clk_pin), .line_sync_pin(line_sync_pin), .line_rx_pin(line_rx_pin),
        .line_tx_data(line_tx_data), .data_strobe_one(data_strobe_one),
        .data_strobe_two(data_strobe_two), .ctrl_tx_bit(ctrl_tx_bit), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data));
    line_xcvr_model u_line (.ref_clk(ref_clk), .line_clk_pin(line_clk_pin),
        .line_sync_pin(line_sync_pin), .line_rx_pin(line_rx_pin));
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    function automatic logic routed(input logic [1:0] c, input logic [15:0] m);
        return c == 2'b01 || (c == 2'b10 && !m[MUX_CTRL2_BIT]) || (c == 2'b11 && !m[MUX_CTRL3_BIT]);
    endfunction
    // One frame under mode m; strobes checked mid channel, routing via the status flags
    task automatic run_frame(input logic [15:0] m, input logic [7:0] b1, input logic [7:0] b2);
        logic drop;
        logic ovf;
        logic [1:0] c;
        drop = 1'b0;
        ovf = 1'b0;
        reg_wr(ADDR_MODE, m);
        reg_wr(ADDR_STATUS, 16'h000f);
        fork
            u_line.send_frame(b1, b2, m[SYNC_STYLE_BIT]);
            begin
                wait (u_line.bit_no == 5);
                repeat (6) @(posedge ref_clk);
                #1 `CHK(strobes, m[STROBE_FIRST_BIT] ? 2'b10 : 2'b01)
                wait (u_line.bit_no == 13);
                repeat (6) @(posedge ref_clk);
                #1 `CHK(strobes, m[STROBE_SECOND_BIT] ? 2'b01 : 2'b10)
            end
        join
        for (int i = 0; i < 2; i++) begin
            c = (i == 1) ? m[9:8] : m[7:6];
            if (!routed(c, m)) begin
                drop = 1'b1;
            end else if (exp_q.size() < FIFO_DEPTH) begin
                exp_q.push_back({c, (i == 1) ? b2 : b1});
            end else begin
                ovf = 1'b1;
            end
        end
        repeat (8) @(posedge ref_clk);
        reg_rd(ADDR_STATUS, rd);
        `CHK(rd[ST_DROP_BIT], drop)
        `CHK(rd[ST_FIFO_OVF_BIT], ovf)
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        reg_rd(ADDR_MODE, rd);
        `CHK(rd, MODE_RESET)
        reg_wr(ADDR_MODE, 16'ha5c3);
        reg_rd(ADDR_MODE, rd);
        `CHK(rd, 16'ha5c3)
        reg_wr(4'h9, 16'hffff);
        reg_rd(4'h9, rd);
        `CHK(rd, READ_ZERO)
        reg_wr(ADDR_CONFIG, 16'hffff);
        reg_rd(ADDR_CONFIG, rd);
        `CHK(rd, 16'h0001)
        $display("test registers done");
        u_line.pulse(6, 1'b0, 1'b0);
        for (int d = 0; d < 4; d++) begin
            for (int b = 0; b < 2; b++) begin
                @(posedge ref_clk);
                ctrl_tx_bit <= b[0];
                reg_wr(ADDR_MODE, {2'b00, d[1:0], 12'h000});
                repeat (6) @(posedge ref_clk);
                #1 `CHK(line_tx_data, d == 1 ? u_line.line_rx_pin : (d == 2 ? 1'b1 : b[0]))
            end
        end
        reg_wr(ADDR_MODE, 16'h8000);
        repeat (4) @(posedge ref_clk);
        #1 `CHK(line_tx_data, 1'b0)
        $display("test transmit modes done");
        for (int k = 0; k < 5; k++) begin
            run_frame(modes[k], 8'h96 ^ k[7:0], 8'h3c + k[7:0]);
        end
        for (int k = 0; exp_q.size() < FIFO_DEPTH; k++) begin
            run_frame(16'h0240, 8'h50 + k[7:0], 8'ha0 - k[7:0]);
        end
        run_frame(16'h0240, 8'hff, 8'h00);
        while (exp_q.size() > 0) begin
            @(posedge ref_clk);
            #1 `CHK(out_valid, 1'b1)
            rd[ROUTED_W-1:0] = exp_q.pop_front();
            `CHK(out_data, rd[ROUTED_W-1:0])
            @(posedge ref_clk);
            out_ready <= 1'b1;
            @(posedge ref_clk);
            out_ready <= 1'b0;
        end
        @(posedge ref_clk);
        #1 `CHK(out_valid, 1'b0)
        $display("test routing and buffer done");
        reg_wr(ADDR_STATUS, 16'h000f);
        u_line.pulse(2, 1'b0, 1'b0);
        repeat (8) @(posedge ref_clk);
        reg_rd(ADDR_STATUS, rd);
        `CHK(rd[ST_UNDERRUN_BIT], 1'b1)
        reg_wr(ADDR_STATUS, 16'h000f);
        reg_wr(ADDR_CONFIG, 16'h0000);
        u_line.pulse(2, 1'b1, 1'b0);
        repeat (8) @(posedge ref_clk);
        reg_rd(ADDR_STATUS, rd);
        `CHK(rd[ST_UNDERRUN_BIT], 1'b0)
        $display("test clock phase done");
        report_and_stop();
    end
endmodule
